// file: hdl/psc_defines.svh
// Offsets, field positions, reset values and encodings of the slot and
// power management capability bank. Definitions only.
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

// Register byte offsets
`define PSC_ADDR_PCIE_CAP     12'h080
`define PSC_ADDR_DEV_CAP      12'h084
`define PSC_ADDR_SLOT_CAP     12'h094

// PCIe capability register fields
`define PSC_CAP_ROOT_BIT      0
`define PSC_CAP_SLOT_BIT      1
`define PSC_CAP_LPSEEN_BIT    2
`define PSC_CAP_MSGPEND_BIT   3

// Device capabilities fields
`define PSC_DEV_L0S_LSB       6
`define PSC_DEV_L0S_MSB       8
`define PSC_DEV_L1_LSB        9
`define PSC_DEV_L1_MSB        11

// Slot capabilities fields
`define PSC_SLOT_LIMIT_LSB    7
`define PSC_SLOT_LIMIT_MSB    14
`define PSC_SLOT_SCALE_LSB    15
`define PSC_SLOT_SCALE_MSB    16
`define PSC_SLOT_NUM_LSB      19
`define PSC_SLOT_NUM_MSB      31

// Reset values
`define PSC_SCALE_RESET       2'h0
`define PSC_LIMIT_RESET       8'h00

// Scale multipliers in milliwatts per limit unit
`define PSC_MULT_1X           18'h003e8
`define PSC_MULT_0P1X         18'h00064
`define PSC_MULT_0P01X        18'h0000a
`define PSC_MULT_0P001X       18'h00001

// L0s acceptable latency codes, ascending
`define PSC_L0S_64NS          3'h0
`define PSC_L0S_128NS         3'h1
`define PSC_L0S_256NS         3'h2
`define PSC_L0S_512NS         3'h3
`define PSC_L0S_1US           3'h4
`define PSC_L0S_2US           3'h5
`define PSC_L0S_4US           3'h6
`define PSC_LAT_NO_LIMIT      3'h7

// L1 acceptable latency codes, ascending
`define PSC_L1_1US            3'h0
`define PSC_L1_2US            3'h1
`define PSC_L1_4US            3'h2
`define PSC_L1_8US            3'h3
`define PSC_L1_16US           3'h4
`define PSC_L1_32US           3'h5

`endif

// file: hdl/psc_pkg.sv
// Types of the slot and power management capability bank.
// Needs nothing from psc_defines.svh; the state encodings are given here.
package psc_pkg;

   typedef enum logic [2:0] {
      PSC_INIT   = 3'b001,
      PSC_RUN    = 3'b010,
      PSC_LOWPWR = 3'b100
   } psc_fsm_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } psc_bus_req_t;

   typedef struct packed {
      logic [1:0] scale;
      logic [7:0] limit;
   } psc_msg_t;

endpackage

// file: hdl/psc_msg_tx.sv
// Holds the latest slot power limit message until the link side accepts it.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "psc_defines.svh"

module psc_msg_tx
   import psc_pkg::*;
(
   input  wire logic     clk_in,
   input  wire logic     reset_in,
   input  wire logic     send_in,
   input  wire psc_msg_t payload_in,
   input  wire logic     msg_ready_in,
   output logic          msg_valid_out,
   output psc_msg_t      msg_out
);

   typedef struct packed {
      logic     valid;
      psc_msg_t msg;
   } psc_tx_state_t;

   psc_tx_state_t st;
   psc_tx_state_t next_st;

   always_comb begin
      next_st = st;
      if (st.valid && msg_ready_in) begin
         next_st.valid = 1'b0;
      end
      // New request wins over acceptance of the old one
      if (send_in) begin
         next_st.valid = 1'b1;
         next_st.msg   = payload_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign msg_valid_out = st.valid;
   assign msg_out       = st.msg;

   property p_msg_hold;
      @(posedge clk_in) disable iff (reset_in)
      msg_valid_out && !msg_ready_in && !send_in
      |=> msg_valid_out && msg_out == $past(msg_out);
   endproperty
   a_msg_hold: assert property (p_msg_hold) else $error("Message dropped");

endmodule

// file: hdl/psc_cap_regs.sv
// Slot capability and power management capability register bank.
// Assumes a plain register port on clk_in and asynchronous link pins.
`timescale 1ns/1ps
`include "psc_defines.svh"

module psc_cap_regs
   import psc_pkg::*;
#(
   parameter bit          ROOT_PORT   = 1'b1,
   parameter bit          SLOT_IMPL   = 1'b1,
   parameter logic [1:0]  SLOT_SCALE  = 2'h0,
   parameter logic [7:0]  SLOT_LIMIT  = 8'h19,
   parameter logic [12:0] SLOT_NUMBER = 13'h0001,
   parameter logic [2:0]  L0S_LAT     = `PSC_L0S_64NS,
   parameter logic [2:0]  L1_LAT      = `PSC_L1_1US
)
(
   input  wire logic          clk_in,
   input  wire logic          reset_in,
   input  wire psc_bus_req_t  bus_in,
   output logic [31:0]        rdata_out,
   input  wire logic          link_low_power_in,
   input  wire logic          perst_n_in,
   input  wire logic          msg_ready_in,
   output logic               msg_valid_out,
   output psc_msg_t           msg_out,
   output logic [1:0]         slot_power_scale_out,
   output logic [7:0]         slot_power_limit_out,
   output logic [17:0]        slot_power_mw_out,
   output logic               link_low_power_out,
   output logic               l0s_enter_out,
   output logic               l1_enter_out,
   output logic               beacon_out,
   output logic               wake_out
);

   localparam bit SLOT_ON = ROOT_PORT && SLOT_IMPL;

   typedef struct packed {
      psc_fsm_t    state;
      logic [1:0]  sync1;
      logic [1:0]  sync2;
      logic [1:0]  scale;
      logic [7:0]  limit;
      logic [17:0] power_mw;
      logic        send;
      logic        lp_seen;
      logic [31:0] rdata;
   } psc_regs_state_t;

   psc_regs_state_t st;
   psc_regs_state_t next_st;
   logic            lp_sync;
   logic            perst_n_sync;
   logic            slot_wr;
   logic [17:0]     mult;
   psc_msg_t        payload;

   assign lp_sync      = st.sync2[0];
   assign perst_n_sync = st.sync2[1];
   assign slot_wr      = bus_in.wr && bus_in.addr == `PSC_ADDR_SLOT_CAP && SLOT_ON
                         && st.state != PSC_INIT;

   always_comb begin
      next_st      = st;
      next_st.send = 1'b0;
      mult         = `PSC_MULT_1X;
      // Pins pass two stages first
      next_st.sync1 = {perst_n_in, link_low_power_in};
      next_st.sync2 = st.sync1;
      case (st.state)
         PSC_INIT: begin
            next_st.scale = SLOT_SCALE;
            next_st.limit = SLOT_LIMIT;
            next_st.state = PSC_RUN;
         end
         PSC_RUN: begin
            if (lp_sync) begin
               next_st.lp_seen = 1'b1;
               next_st.state   = PSC_LOWPWR;
            end
         end
         PSC_LOWPWR: begin
            if (!perst_n_sync) begin
               next_st.lp_seen = 1'b0;
               next_st.state   = PSC_INIT;
            end
         end
         default: begin
            next_st.state = PSC_INIT;
         end
      endcase
      if (slot_wr) begin
         next_st.limit = bus_in.wdata[`PSC_SLOT_LIMIT_MSB:`PSC_SLOT_LIMIT_LSB];
         next_st.scale = bus_in.wdata[`PSC_SLOT_SCALE_MSB:`PSC_SLOT_SCALE_LSB];
         next_st.send  = 1'b1;
      end
      case (next_st.scale)
         2'h0:    mult = `PSC_MULT_1X;
         2'h1:    mult = `PSC_MULT_0P1X;
         2'h2:    mult = `PSC_MULT_0P01X;
         2'h3:    mult = `PSC_MULT_0P001X;
         default: mult = `PSC_MULT_1X;
      endcase
      next_st.power_mw = 18'({10'h000, next_st.limit} * mult);
      next_st.rdata    = 32'h00000000;
      if (bus_in.rd) begin
         case (bus_in.addr)
            `PSC_ADDR_PCIE_CAP: begin
               next_st.rdata[`PSC_CAP_ROOT_BIT]    = ROOT_PORT;
               next_st.rdata[`PSC_CAP_SLOT_BIT]    = SLOT_IMPL;
               next_st.rdata[`PSC_CAP_LPSEEN_BIT]  = st.lp_seen;
               next_st.rdata[`PSC_CAP_MSGPEND_BIT] = msg_valid_out;
            end
            `PSC_ADDR_DEV_CAP: begin
               if (!ROOT_PORT) begin
                  next_st.rdata[`PSC_DEV_L0S_MSB:`PSC_DEV_L0S_LSB] = L0S_LAT;
                  next_st.rdata[`PSC_DEV_L1_MSB:`PSC_DEV_L1_LSB]   = L1_LAT;
               end
            end
            `PSC_ADDR_SLOT_CAP: begin
               if (SLOT_ON) begin
                  next_st.rdata[`PSC_SLOT_LIMIT_MSB:`PSC_SLOT_LIMIT_LSB] = st.limit;
                  next_st.rdata[`PSC_SLOT_SCALE_MSB:`PSC_SLOT_SCALE_LSB] = st.scale;
                  next_st.rdata[`PSC_SLOT_NUM_MSB:`PSC_SLOT_NUM_LSB]     = SLOT_NUMBER;
               end
            end
            default: begin
               next_st.rdata = 32'h00000000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         st          <= '0;
         st.state    <= PSC_INIT;
         st.sync1    <= 2'h2;
         st.sync2    <= 2'h2;
         st.scale    <= `PSC_SCALE_RESET;
         st.limit    <= `PSC_LIMIT_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign payload = '{scale: st.scale, limit: st.limit};

   psc_msg_tx u_msg_tx (
      .clk_in        (clk_in),
      .reset_in      (reset_in),
      .send_in       (st.send),
      .payload_in    (payload),
      .msg_ready_in  (msg_ready_in),
      .msg_valid_out (msg_valid_out),
      .msg_out       (msg_out)
   );

   assign rdata_out            = st.rdata;
   assign slot_power_scale_out = st.scale;
   assign slot_power_limit_out = st.limit;
   assign slot_power_mw_out    = st.power_mw;
   assign link_low_power_out   = st.lp_seen;
   assign l0s_enter_out        = 1'b0;
   assign l1_enter_out         = 1'b0;
   assign beacon_out           = 1'b0;
   assign wake_out             = 1'b0;

   // Checks
   property p_slot_hidden;
      @(posedge clk_in) disable iff (reset_in)
      bus_in.rd && bus_in.addr == `PSC_ADDR_SLOT_CAP && !SLOT_ON |=> rdata_out == 32'h0;
   endproperty
   a_slot_hidden: assert property (p_slot_hidden) else $error("Slot cap visible");

   property p_status_in_cap;
      @(posedge clk_in) disable iff (reset_in)
      bus_in.rd && bus_in.addr == `PSC_ADDR_PCIE_CAP
      |=> rdata_out[`PSC_CAP_LPSEEN_BIT] == $past(link_low_power_out);
   endproperty
   a_status_in_cap: assert property (p_status_in_cap) else $error("Status wrong");

   property p_scale_decode;
      @(posedge clk_in) disable iff (reset_in)
      slot_power_scale_out == 2'h1
      |-> slot_power_mw_out == 18'({10'h0, slot_power_limit_out} * 18'h64);
   endproperty
   a_scale_decode: assert property (p_scale_decode) else $error("Scale decode wrong");

   property p_scale_div1;
      @(posedge clk_in) disable iff (reset_in)
      slot_power_scale_out == 2'h0
      |-> slot_power_mw_out == 18'({10'h0, slot_power_limit_out} * `PSC_MULT_1X);
   endproperty
   a_scale_div1: assert property (p_scale_div1) else $error("Scale 0 wrong");

   property p_scale_div100;
      @(posedge clk_in) disable iff (reset_in)
      slot_power_scale_out == 2'h2
      |-> slot_power_mw_out == 18'({10'h0, slot_power_limit_out} * `PSC_MULT_0P01X);
   endproperty
   a_scale_div100: assert property (p_scale_div100) else $error("Scale 2 wrong");

   property p_scale_div1000;
      @(posedge clk_in) disable iff (reset_in)
      slot_power_scale_out == 2'h3
      |-> slot_power_mw_out == 18'({10'h0, slot_power_limit_out} * `PSC_MULT_0P001X);
   endproperty
   a_scale_div1000: assert property (p_scale_div1000) else $error("Scale 3 wrong");

   property p_init_zero;
      @(posedge clk_in) disable iff (reset_in)
      st.state == PSC_INIT |-> slot_power_scale_out == 2'h0 || $past(st.state) == PSC_LOWPWR;
   endproperty
   a_init_zero: assert property (p_init_zero) else $error("Scale not zero at init");

   property p_write_sends;
      @(posedge clk_in) disable iff (reset_in)
      slot_wr |=> st.send ##1 msg_valid_out
                  && msg_out.limit
                  == $past(bus_in.wdata[`PSC_SLOT_LIMIT_MSB:`PSC_SLOT_LIMIT_LSB], 2);
   endproperty
   a_write_sends: assert property (p_write_sends) else $error("No limit message");

   property p_msg_scale;
      @(posedge clk_in) disable iff (reset_in)
      slot_wr |-> ##2 msg_out.scale
                  == $past(bus_in.wdata[`PSC_SLOT_SCALE_MSB:`PSC_SLOT_SCALE_LSB], 2);
   endproperty
   a_msg_scale: assert property (p_msg_scale) else $error("Message scale wrong");

   property p_limit_store;
      @(posedge clk_in) disable iff (reset_in)
      slot_wr |=> slot_power_limit_out
                  == $past(bus_in.wdata[`PSC_SLOT_LIMIT_MSB:`PSC_SLOT_LIMIT_LSB]);
   endproperty
   a_limit_store: assert property (p_limit_store) else $error("Limit not stored");

   property p_init_load;
      @(posedge clk_in) disable iff (reset_in)
      st.state == PSC_RUN && $past(st.state) == PSC_INIT
      |-> slot_power_scale_out == SLOT_SCALE && slot_power_limit_out == SLOT_LIMIT;
   endproperty
   a_init_load: assert property (p_init_load) else $error("Parameters not loaded");

   property p_slot_number;
      @(posedge clk_in) disable iff (reset_in)
      bus_in.rd && bus_in.addr == `PSC_ADDR_SLOT_CAP && SLOT_ON
      |=> rdata_out[`PSC_SLOT_NUM_MSB:`PSC_SLOT_NUM_LSB] == SLOT_NUMBER;
   endproperty
   a_slot_number: assert property (p_slot_number) else $error("Slot number wrong");

   property p_l0s_field;
      @(posedge clk_in) disable iff (reset_in)
      bus_in.rd && bus_in.addr == `PSC_ADDR_DEV_CAP && !ROOT_PORT
      |=> rdata_out[`PSC_DEV_L0S_MSB:`PSC_DEV_L0S_LSB] == L0S_LAT;
   endproperty
   a_l0s_field: assert property (p_l0s_field) else $error("L0s latency wrong");

   property p_l1_field;
      @(posedge clk_in) disable iff (reset_in)
      bus_in.rd && bus_in.addr == `PSC_ADDR_DEV_CAP && !ROOT_PORT
      |=> rdata_out[`PSC_DEV_L1_MSB:`PSC_DEV_L1_LSB] == L1_LAT;
   endproperty
   a_l1_field: assert property (p_l1_field) else $error("L1 latency wrong");

   property p_root_no_lat;
      @(posedge clk_in) disable iff (reset_in)
      bus_in.rd && bus_in.addr == `PSC_ADDR_DEV_CAP && ROOT_PORT
      |=> rdata_out[`PSC_DEV_L1_MSB:`PSC_DEV_L0S_LSB] == 6'h00;
   endproperty
   a_root_no_lat: assert property (p_root_no_lat) else $error("Root reports latency");

   property p_ro_fields;
      @(posedge clk_in) disable iff (reset_in)
      bus_in.wr && bus_in.addr != `PSC_ADDR_SLOT_CAP && st.state == PSC_RUN
      |=> $stable(slot_power_scale_out) && $stable(slot_power_limit_out);
   endproperty
   a_ro_fields: assert property (p_ro_fields) else $error("Refused write landed");

   property p_no_aspm;
      @(posedge clk_in) disable iff (reset_in)
      !l0s_enter_out && !l1_enter_out;
   endproperty
   a_no_aspm: assert property (p_no_aspm) else $error("Low power entry");

   property p_lp_exit;
      @(posedge clk_in) disable iff (reset_in)
      st.state == PSC_LOWPWR && !perst_n_sync |=> st.state == PSC_INIT ##1 st.state == PSC_RUN;
   endproperty
   a_lp_exit: assert property (p_lp_exit) else $error("No exit from low power");

   property p_lp_hold;
      @(posedge clk_in) disable iff (reset_in)
      st.state == PSC_LOWPWR && perst_n_sync |=> st.state == PSC_LOWPWR;
   endproperty
   a_lp_hold: assert property (p_lp_hold) else $error("Left low power early");

   property p_no_wake;
      @(posedge clk_in) disable iff (reset_in)
      !beacon_out && !wake_out;
   endproperty
   a_no_wake: assert property (p_no_wake) else $error("Wake signalled");

   property p_cov_write;
      @(posedge clk_in) disable iff (reset_in)
      slot_wr ##2 msg_valid_out && msg_ready_in;
   endproperty
   c_cov_write: cover property (p_cov_write);

   property p_cov_lowpwr;
      @(posedge clk_in) disable iff (reset_in)
      st.state == PSC_LOWPWR ##[1:20] st.state == PSC_RUN;
   endproperty
   c_cov_lowpwr: cover property (p_cov_lowpwr);

   property p_cov_devcap;
      @(posedge clk_in) disable iff (reset_in)
      bus_in.rd && bus_in.addr == `PSC_ADDR_DEV_CAP;
   endproperty
   c_cov_devcap: cover property (p_cov_devcap);

   property p_cov_stall;
      @(posedge clk_in) disable iff (reset_in)
      msg_valid_out && !msg_ready_in ##1 st.send;
   endproperty
   c_cov_stall: cover property (p_cov_stall);

endmodule

// file: bench/psc_link_model.sv
// Link side partner that takes slot power limit messages from the port.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps

module psc_link_model
   import psc_pkg::*;
(
   input  wire logic     clk_in,
   input  wire logic     reset_in,
   input  wire logic     stall_in,
   input  wire logic     msg_valid_in,
   input  wire psc_msg_t msg_in,
   output logic          msg_ready_out,
   output psc_msg_t      last_msg_out,
   output logic [7:0]    msg_count_out
);
   // Registered ready, held low while stalled
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         msg_ready_out <= 1'b0;
         last_msg_out  <= '0;
         msg_count_out <= 8'h00;
      end else begin
         msg_ready_out <= !stall_in;
         if (msg_valid_in && msg_ready_out) begin
            last_msg_out  <= msg_in;
            msg_count_out <= msg_count_out + 8'h01;
         end
      end
   end
endmodule

// file: bench/psc_cap_regs_tb.sv
// Self-checking bench of the slot and power management capability bank.
// Assumes psc_pkg, psc_defines.svh and the link partner model.
`timescale 1ns/1ps
`include "psc_defines.svh"

module psc_cap_regs_tb
   import psc_pkg::*;
;
   typedef struct packed {
      logic        wr;
      logic [11:0] addr;
      logic [31:0] data;
      logic [31:0] exp;
   } psc_row_t;

   logic         clk_in   = 1'b0;
   logic         reset_in = 1'b1;
   logic         link_lp  = 1'b0;
   logic         perst_n  = 1'b1;
   logic         stall    = 1'b0;
   psc_bus_req_t bus      = '0;
   logic [31:0]  rdata, ep_rdata, r, e;
   logic         msg_ready, msg_valid, ep_msg_valid, lp_out, l0s, l1, beacon, wake;
   logic [1:0]   ep_enter;
   psc_msg_t     msg, last_msg;
   logic [7:0]   msg_count, cnt0, limit;
   logic [1:0]   scale;
   logic [17:0]  mw;
   logic [17:0]  mult [4] = '{`PSC_MULT_1X, `PSC_MULT_0P1X, `PSC_MULT_0P01X, `PSC_MULT_0P001X};
   psc_row_t     rows [8];
   int           errors = 0;
   int           samples_checked = 0;

   always #2.5 clk_in = ~clk_in;

   psc_cap_regs #(.SLOT_SCALE(2'h3)) psc_cap_regs_inst (
      .clk_in(clk_in), .reset_in(reset_in), .bus_in(bus), .rdata_out(rdata),
      .link_low_power_in(link_lp), .perst_n_in(perst_n), .msg_ready_in(msg_ready),
      .msg_valid_out(msg_valid), .msg_out(msg), .slot_power_scale_out(scale),
      .slot_power_limit_out(limit), .slot_power_mw_out(mw), .link_low_power_out(lp_out),
      .l0s_enter_out(l0s), .l1_enter_out(l1), .beacon_out(beacon), .wake_out(wake));

   // Endpoint flavour with non-default latencies
   psc_cap_regs #(.ROOT_PORT(1'b0), .L0S_LAT(`PSC_L0S_512NS), .L1_LAT(`PSC_LAT_NO_LIMIT))
      psc_cap_regs_inst_ep (
      .clk_in(clk_in), .reset_in(reset_in), .bus_in(bus), .rdata_out(ep_rdata),
      .link_low_power_in(1'b0), .perst_n_in(1'b1), .msg_ready_in(1'b1),
      .msg_valid_out(ep_msg_valid), .msg_out(), .slot_power_scale_out(),
      .slot_power_limit_out(), .slot_power_mw_out(), .link_low_power_out(),
      .l0s_enter_out(ep_enter[0]), .l1_enter_out(ep_enter[1]), .beacon_out(), .wake_out());

   psc_link_model psc_link_model_inst (
      .clk_in(clk_in), .reset_in(reset_in), .stall_in(stall), .msg_valid_in(msg_valid),
      .msg_in(msg), .msg_ready_out(msg_ready), .last_msg_out(last_msg),
      .msg_count_out(msg_count));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("Checks %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_in);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_in);
      bus.wr <= 1'b0;
      #1;
   endtask

   task automatic bus_rd(input logic [11:0] a);
      @(posedge clk_in);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk_in);
      bus.rd <= 1'b0;
      #1;
      r = rdata;
      e = ep_rdata;
   endtask

   // Outputs that must never rise
   always @(negedge clk_in) begin
      if (!reset_in) begin
         check({28'h0, l0s, l1, beacon, wake}, 32'h0);
         check({29'h0, ep_msg_valid, ep_enter}, 32'h0);
      end
   end

   initial begin
      #(5000 * 5);
      errors++;
      final_report();
   end

   initial begin
      rows[0] = '{1'b0, 12'h080, 32'h0, 32'h00000003};
      rows[1] = '{1'b0, 12'h084, 32'h0, 32'h00000000};
      rows[2] = '{1'b0, 12'h094, 32'h0, 32'h00098c80};
      rows[3] = '{1'b1, 12'h084, 32'hffffffff, 32'h0};
      rows[4] = '{1'b0, 12'h084, 32'h0, 32'h00000000};
      rows[5] = '{1'b1, 12'h094, 32'hffffffff, 32'h0};
      rows[6] = '{1'b0, 12'h094, 32'h0, 32'h0009ff80};
      rows[7] = '{1'b0, 12'h100, 32'h0, 32'h00000000};
      repeat (15) @(posedge clk_in);
      #1;
      check({22'h0, scale, limit}, 32'h0);
      @(posedge clk_in);
      reset_in <= 1'b0;
      cycles(2);
      $display("Test reset done");
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            bus_wr(rows[i].addr, rows[i].data);
         end else begin
            bus_rd(rows[i].addr);
            check(r, rows[i].exp);
         end
      end
      bus_rd(`PSC_ADDR_DEV_CAP);
      check(e, 32'h00000ec0);
      bus_rd(`PSC_ADDR_SLOT_CAP);
      check(e, 32'h0);
      $display("Test register table done");
      for (int s = 0; s < 4; s++) begin
         cnt0 = msg_count;
         bus_wr(`PSC_ADDR_SLOT_CAP, {15'h0, s[1:0], 8'hc8, 7'h0});
         check({14'h0, mw}, {14'h0, 18'h0000c8 * mult[s]});
         cycles(4);
         check({22'h0, last_msg}, {22'h0, s[1:0], 8'hc8});
         check({24'h0, msg_count}, {24'h0, cnt0 + 8'h01});
      end
      $display("Test power scale done");
      @(posedge clk_in);
      stall <= 1'b1;
      cnt0 = msg_count;
      bus_wr(`PSC_ADDR_SLOT_CAP, {15'h0, 2'h1, 8'h11, 7'h0});
      bus_wr(`PSC_ADDR_SLOT_CAP, {15'h0, 2'h2, 8'h22, 7'h0});
      cycles(6);
      check({31'h0, msg_valid}, 32'h1);
      check({22'h0, msg}, {22'h0, 2'h2, 8'h22});
      bus_rd(`PSC_ADDR_PCIE_CAP);
      check(r, 32'h0000000b);
      @(posedge clk_in);
      stall <= 1'b0;
      cycles(4);
      check({22'h0, last_msg}, {22'h0, 2'h2, 8'h22});
      check({24'h0, msg_count}, {24'h0, cnt0 + 8'h01});
      $display("Test stalled message done");
      @(posedge clk_in);
      link_lp <= 1'b1;
      cycles(6);
      bus_rd(`PSC_ADDR_PCIE_CAP);
      check(r, 32'h00000007);
      @(posedge clk_in);
      link_lp <= 1'b0;
      cycles(4);
      check({31'h0, lp_out}, 32'h1);
      @(posedge clk_in);
      perst_n <= 1'b0;
      cycles(4);
      @(posedge clk_in);
      perst_n <= 1'b1;
      cycles(8);
      check({20'h0, lp_out, 1'b0, scale, limit}, {22'h0, 2'h3, 8'h19});
      $display("Test low power exit done");
      final_report();
   end
endmodule
